// ### src/monitor_instance_select_bank.sv
// monitor instance selector bank with banked bandwidth filter storage
// Operation
// - separate filter copy per security page
// - each filter copy serves own space only
// - filter indexed by resource and monitor index
// - without resource select, monitor index only
// - filter at 0x0820, read-write
// - root filter needs realm extension
// - selector at 0x0800 picks monitor instance
// - monitor index in selector bits 15:0
// - resource field 27:24 present under conditions
// - other registers indexed by index and space
// - out-of-range index may flag error
// - four selector copies, one per space
// - selector present only under feature conditions
// - cache usage value present under conditions
// - cache usage uses resource and index
// - cache usage follows same-space selector
// - direction field 31:30 filter encodings
// - label field 15:0 matches partition
`timescale 1ns/1ps
`default_nettype none
module monitor_instance_select_bank
    import monitor_index_pkg::*;
(
    input  wire logic                     clk,            // 125 MHz clock
    input  wire logic                     rst_b,          // async reset
    input  wire monitor_index_pkg::reg_req_t    req,            // page access
    input  wire monitor_index_pkg::feature_cfg_t cfg,           // presence straps
    input  wire logic [31:0]              cache_usage_value, // selected value
    input  wire monitor_index_pkg::security_space_t count_space, // counting path
    output logic [31:0]                   rdata,          // read data
    output logic                          rvalid,         // read answer
    output logic                          oob_error,      // out-of-bounds pulse
    output logic [15:0]                   cache_monitor_index, // value select
    output logic [3:0]                    cache_resource_index, // value res
    output monitor_index_pkg::security_space_t  cache_space,    // value space
    output monitor_index_pkg::bw_filter_t       count_filter    // counting filter
);
    import monitor_index_pkg::*;

    localparam int FLT_SLOTS = NUM_RES_SLOTS * MONITOR_COUNT_FIELD_SLOTS; // per space
    localparam int SLOT_W    = $clog2(FLT_SLOTS);

    // presence terms
    logic sel_present;      // selector exists
    logic ris_present;      // resource field usable
    logic flt_present;      // bandwidth filter exists
    logic csu_present;      // cache usage value exists
    logic [31:0] flt_mask;  // writable filter bits

    always_comb begin
        sel_present = cfg.monitors_present_flag
            | (cfg.custom_id_present & ~cfg.widened_id_flag)
            | (cfg.custom_id_present & cfg.widened_id_flag
               & ~cfg.no_custom_monitors);
        ris_present = cfg.newer_version & cfg.widened_id_flag
            & cfg.resource_select_present;
        flt_present = cfg.monitors_present_flag & cfg.bw_monitor_present;
        csu_present = cfg.monitors_present_flag
            & cfg.cache_storage_usage;
        // direction bits exist only where the filter supports them
        flt_mask = cfg.direction_filter_present ? FLT_WR_MASK_DIR
                                                : FLT_WR_MASK;
    end

    // banked selectors, one per space
    logic [31:0] sel_r   [NUM_SPACES];   // selector copies
    logic [31:0] sel_nxt [NUM_SPACES];   // next selector values
    // banked filter storage, per space, per resource and monitor slot
    logic [31:0] flt_r   [NUM_SPACES][FLT_SLOTS]; // filter copies
    logic [31:0] flt_nxt [NUM_SPACES][FLT_SLOTS]; // next filter values
    logic [31:0] rdata_nxt;              // next read data
    logic        rvalid_nxt;             // next read answer
    logic        oob_nxt;                // next error pulse
    logic        oob_r;                  // error flop

    // current access decode
    logic [31:0] cur_sel;       // selector of the accessing space
    logic [15:0] cur_idx;       // its monitor index
    logic [3:0]  cur_res;       // its resource field, zero if absent
    logic [SLOT_W-1:0] cur_slot; // storage slot of the filter
    logic        slot_ok;       // index fits the stored monitors
    logic        space_ok;      // root and realm pages need the extension

    always_comb begin
        cur_sel  = sel_r[req.space];
        cur_idx  = cur_sel[SEL_IDX_LSB +: MON_IDX_W];
        // resource field is ignored when resource select is absent
        cur_res  = ris_present ? cur_sel[SEL_RIS_LSB +: RIS_W]
                               : 4'h0;
        slot_ok  = (cur_idx < cfg.bw_monitor_count_field)
            && (cur_idx < 16'(MONITOR_COUNT_FIELD_SLOTS))
            && (cur_res < 4'(NUM_RES_SLOTS));
        cur_slot = SLOT_W'({cur_res[0], cur_idx[3:0]});
        space_ok = (req.space == SPACE_SECURE)
            || (req.space == SPACE_NONSEC)
            || cfg.realm_extension;
    end

    // next-state for selectors, filters and the read path
    always_comb begin
        sel_nxt    = sel_r;
        flt_nxt    = flt_r;
        rdata_nxt  = 32'h0000_0000;
        rvalid_nxt = 1'b0;
        oob_nxt    = 1'b0;
        if (req.valid && space_ok) begin
            rvalid_nxt = ~req.write;
            unique case (req.offset)
                OFS_MONITOR_INDEX: begin
                    if (sel_present) begin
                        if (req.write) begin
                            // reserved bits, and the resource field when
                            // absent, are dropped on write
                            sel_nxt[req.space] = req.wdata
                                & SEL_WR_MASK
                                & (ris_present ? 32'hffff_ffff
                                               : 32'h00ff_ffff);
                        end else begin
                            rdata_nxt = cur_sel;
                        end
                    end
                end
                OFS_BW_FLT: begin
                    if (flt_present) begin
                        if (!slot_ok) begin
                            oob_nxt = 1'b1;
                        end else if (req.write) begin
                            // only the copy of the accessing space moves
                            flt_nxt[req.space][cur_slot] =
                                req.wdata & flt_mask;
                        end else begin
                            rdata_nxt = flt_r[req.space][cur_slot];
                        end
                    end
                end
                OFS_CSU_VAL: begin
                    if (csu_present && !req.write) begin
                        rdata_nxt = cache_usage_value;
                    end
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;  // unmapped reads zero
                end
            endcase
        end else if (req.valid) begin
            // root or realm page without the extension: reads zero
            rvalid_nxt = ~req.write;
        end
    end

    // registers only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int s = 0; s < NUM_SPACES; s++) begin
                sel_r[s] <= SEL_RESET;
                for (int m = 0; m < FLT_SLOTS; m++) begin
                    flt_r[s][m] <= FLT_RESET;
                end
            end
            rdata  <= 32'h0000_0000;
            rvalid <= 1'b0;
            oob_r  <= 1'b0;
        end else begin
            sel_r  <= sel_nxt;
            flt_r  <= flt_nxt;
            rdata  <= rdata_nxt;
            rvalid <= rvalid_nxt;
            oob_r  <= oob_nxt;
        end
    end

    assign oob_error = oob_r;

    // cache value select follows the selector of the same space
    logic [31:0] csu_sel;   // selector used for the value path
    always_comb begin
        csu_sel              = sel_r[req.space];
        cache_space          = req.space;
        cache_monitor_index  = csu_sel[SEL_IDX_LSB +: MON_IDX_W];
        cache_resource_index = ris_present
            ? csu_sel[SEL_RIS_LSB +: RIS_W] : 4'h0;
    end

    // filter seen by the counting path: that space's own selected monitor;
    // label match itself lives in the counter, outside this bank
    logic [31:0] cnt_sel;        // selector of the counting space
    logic [SLOT_W-1:0] cnt_slot; // slot it names
    logic [31:0] cnt_word;       // stored filter word
    always_comb begin
        cnt_sel  = sel_r[count_space];
        cnt_slot = SLOT_W'({ris_present & cnt_sel[SEL_RIS_LSB],
                            cnt_sel[3:0]});
        cnt_word = flt_r[count_space][cnt_slot];
        count_filter.direction_filter = cnt_word[FLT_DIR_LSB +: 2];
        count_filter.perf_group_label = cnt_word[FLT_PG_LSB +: 8];
        count_filter.partition_label  = cnt_word[15:0];
    end
endmodule : monitor_instance_select_bank
`default_nettype wire

// ### src/monitor_index_pkg.sv
// package: offsets, fields, resets and types of the monitor selector bank
package monitor_index_pkg;
    localparam int          ADDR_W        = 12;     // frame offset width
    localparam int          DATA_W        = 32;     // register width
    localparam int          NUM_SPACES    = 4;      // secure, non-secure, root, realm
    localparam int          MON_IDX_W     = 16;     // monitor index width
    localparam int          RIS_W         = 4;      // resource selector width
    localparam int          MONITOR_COUNT_FIELD_SLOTS = 16;     // stored filter monitors
    localparam int          NUM_RES_SLOTS = 2;      // stored resource instances
    localparam logic [11:0] OFS_MONITOR_INDEX   = 12'h800;  // selector offset
    localparam logic [11:0] OFS_BW_FLT    = 12'h820;  // bandwidth filter offset
    localparam logic [11:0] OFS_CSU_VAL   = 12'h840;  // cache usage value offset
    localparam int          SEL_IDX_LSB   = 0;      // monitor index position
    localparam int          SEL_RIS_LSB   = 24;     // resource field position
    localparam logic [31:0] SEL_WR_MASK   = 32'h0f00_ffff; // writable bits
    localparam logic [31:0] FLT_WR_MASK_DIR = 32'hc0ff_ffff; // with direction
    localparam logic [31:0] FLT_WR_MASK   = 32'h00ff_ffff; // without direction
    localparam logic [31:0] SEL_RESET     = 32'h0000_0000; // selector reset
    localparam logic [31:0] FLT_RESET     = 32'h0000_0000; // filter reset
    localparam int          FLT_DIR_LSB   = 30;     // direction field position
    localparam int          FLT_PG_LSB    = 16;     // perf group position
    localparam logic [1:0]  DIR_BOTH      = 2'h0;   // count reads and writes
    localparam logic [1:0]  DIR_WR_ONLY   = 2'h1;   // count writes only
    localparam logic [1:0]  DIR_RD_ONLY   = 2'h2;   // count reads only
    localparam logic [1:0]  DIR_RSVD      = 2'h3;   // reserved encoding

    // security space encoding of the page an access came through
    typedef enum logic [1:0] {
        SPACE_SECURE = 2'b00,
        SPACE_NONSEC = 2'b01,
        SPACE_ROOT   = 2'b10,
        SPACE_REALM  = 2'b11
    } security_space_t;

    // one register access from a feature page
    typedef struct packed {
        logic            valid;
        logic            write;
        security_space_t space;
        logic [11:0]     offset;
        logic [31:0]     wdata;
    } reg_req_t;

    // presence straps of the component
    typedef struct packed {
        logic monitors_present_flag;
        logic custom_id_present;
        logic widened_id_flag;
        logic no_custom_monitors;
        logic resource_select_present;
        logic newer_version;
        logic bw_monitor_present;
        logic cache_storage_usage;
        logic direction_filter_present;
        logic realm_extension;
        logic [15:0] bw_monitor_count_field;
    } feature_cfg_t;

    // filter settings of the monitor selected for the counting path
    typedef struct packed {
        logic [1:0]  direction_filter;
        logic [7:0]  perf_group_label;
        logic [15:0] partition_label;
    } bw_filter_t;
endpackage : monitor_index_pkg

// ### dv/monitor_index_props.sv
// checker: timing and field relations at the selector bank ports
`timescale 1ns/1ps
`default_nettype none
module monitor_index_props
    import monitor_index_pkg::*;
(
    input wire logic            clk,
    input wire logic            rst_b,
    input wire reg_req_t        req,
    input wire feature_cfg_t    cfg,
    input wire logic [31:0]     cache_usage_value,
    input wire security_space_t count_space,
    input wire logic [31:0]     rdata,
    input wire logic            rvalid,
    input wire logic            oob_error,
    input wire logic [15:0]     cache_monitor_index,
    input wire logic [3:0]      cache_resource_index,
    input wire security_space_t cache_space,
    input wire bw_filter_t      count_filter
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic rd_q; // a read taken at this edge
    logic fl_q; // a filter access taken at this edge
    assign rd_q = req.valid && !req.write;
    assign fl_q = req.valid && req.offset == OFS_BW_FLT;
    a_read_answer: assert property (rd_q |=> rvalid)
        else $error("read not answered");
    a_write_silent: assert property (req.valid && req.write |=> !rvalid)
        else $error("write answered");
    a_sel_rsvd: assert property (rd_q && req.offset == OFS_MONITOR_INDEX
        |=> rdata[31:28] == 4'h0 && rdata[23:16] == 8'h00)
        else $error("reserved selector bits set");
    a_gated_space: assert property (rd_q && req.space[1]
        && !cfg.realm_extension |=> rdata == 32'h0)
        else $error("gated page read nonzero");
    a_csu_pass: assert property (rd_q && req.offset == OFS_CSU_VAL
        && !req.space[1] && cfg.monitors_present_flag
        && cfg.cache_storage_usage |=> rdata == $past(cache_usage_value))
        else $error("cache usage value not passed");
    a_csu_space: assert property (req.valid |-> cache_space == req.space)
        else $error("cache space differs from page");
    a_oob_flag: assert property (fl_q && (!req.space[1]
        || cfg.realm_extension)
        && cache_monitor_index >= cfg.bw_monitor_count_field |=> oob_error)
        else $error("out of range access not flagged");
    a_oob_quiet: assert property (!fl_q |=> !oob_error)
        else $error("spurious out of range flag");
    a_sel_index: assert property (req.valid && req.write
        && req.offset == OFS_MONITOR_INDEX && !req.space[1]
        && cfg.monitors_present_flag ##1 req.space == $past(req.space)
        |-> cache_monitor_index == $past(req.wdata[15:0]))
        else $error("selected index not shown");
    c_read: cover property (rvalid);
    c_oob: cover property (oob_error);
    c_csu: cover property (rd_q && req.offset == OFS_CSU_VAL);
endmodule : monitor_index_props
bind monitor_instance_select_bank monitor_index_props u_props (.clk(clk),
    .rst_b(rst_b), .req(req), .cfg(cfg),
    .cache_usage_value(cache_usage_value), .count_space(count_space),
    .rdata(rdata), .rvalid(rvalid), .oob_error(oob_error),
    .cache_monitor_index(cache_monitor_index),
    .cache_resource_index(cache_resource_index),
    .cache_space(cache_space), .count_filter(count_filter));
`default_nettype wire

// ### dv/monitor_instance_select_bank_test.sv
// testbench: register accesses through the four pages with expected values
`timescale 1ns/1ps
`default_nettype none
module monitor_instance_select_bank_test;
    import monitor_index_pkg::*;
    logic            clk;
    logic            rst_b;
    reg_req_t        req;
    feature_cfg_t    cfg;
    logic [31:0]     cache_usage_value;
    security_space_t count_space;
    logic [31:0]     rdata;
    logic            rvalid;
    logic            oob_error;
    logic [15:0]     cache_monitor_index;
    logic [3:0]      cache_resource_index;
    security_space_t cache_space;
    bw_filter_t      count_filter;
    int              err_total;
    int              n_compared;
    logic [31:0]     last_rdata;  // read data seen while it stands
    logic            last_rvalid; // read answer seen while it stands
    logic            last_oob;    // error pulse seen while it stands
    monitor_instance_select_bank uut (.clk(clk), .rst_b(rst_b), .req(req),
        .cfg(cfg), .cache_usage_value(cache_usage_value),
        .count_space(count_space), .rdata(rdata), .rvalid(rvalid),
        .oob_error(oob_error), .cache_monitor_index(cache_monitor_index),
        .cache_resource_index(cache_resource_index),
        .cache_space(cache_space), .count_filter(count_filter));
    always #4 clk = ~clk; // 125 MHz
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one access, launched after a falling edge; the one-cycle answer is
    // captured at the next falling edge, then one idle cycle follows so
    // that valid is never driven twice in one time step
    task automatic acc(input logic wr, input logic [1:0] sp,
                       input logic [11:0] ofs, input logic [31:0] wd);
        req = '{1'b1, wr, security_space_t'(sp), ofs, wd};
        @(negedge clk);
        last_rdata  = rdata;
        last_rvalid = rvalid;
        last_oob    = oob_error;
        req.valid   = 1'b0;
        @(negedge clk);
    endtask : acc
    task automatic rd(input logic [1:0] sp, input logic [11:0] ofs,
                      input logic [31:0] exp);
        acc(1'b0, sp, ofs, 32'h0);
        chk(last_rdata, exp);
        chk(32'(last_rvalid), 32'h1);
    endtask : rd
    // watchdog: the sequence needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        req = '0;
        cache_usage_value = 32'h8000_1234;
        count_space = SPACE_SECURE;
        cfg = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
                1'b1, 16'h0008}; // eight filter monitors
        err_total = 0;
        n_compared = 0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        rd(2'd0, OFS_MONITOR_INDEX, SEL_RESET);
        rd(2'd0, OFS_BW_FLT, FLT_RESET);
        for (int s = 0; s < 4; s++) begin
            acc(1'b1, 2'(s), OFS_MONITOR_INDEX, 32'hf1ff_0000 | 32'(s + 1));
            rd(2'(s), OFS_MONITOR_INDEX, 32'h0100_0000 | 32'(s + 1));
            acc(1'b1, 2'(s), OFS_BW_FLT,
                {2'(s), 6'h3f, 8'h10 + 8'(s), 16'ha000 + 16'(s)});
        end
        // every page keeps its own selector and filter copy
        for (int s = 0; s < 4; s++) begin
            count_space = security_space_t'(s);
            rd(2'(s), OFS_BW_FLT, {2'(s), 6'h0, 8'h10 + 8'(s), 16'ha000 + 16'(s)});
            chk(32'(count_filter), {6'h0, 2'(s), 8'h10 + 8'(s), 16'ha000 + 16'(s)});
        end
        acc(1'b1, 2'd0, OFS_MONITOR_INDEX, 32'h0000_0002);
        rd(2'd0, OFS_BW_FLT, 32'h0);
        acc(1'b1, 2'd0, OFS_BW_FLT, 32'h4055_1234);
        rd(2'd0, OFS_BW_FLT, 32'h4055_1234);
        acc(1'b1, 2'd0, OFS_MONITOR_INDEX, 32'h0100_0001);
        rd(2'd0, OFS_BW_FLT, 32'h0010_a000);
        acc(1'b1, 2'd0, OFS_MONITOR_INDEX, 32'h0000_0008);
        acc(1'b1, 2'd0, OFS_BW_FLT, 32'h0011_1111);
        chk(32'(last_oob), 32'h1);
        rd(2'd0, OFS_BW_FLT, 32'h0);
        chk(32'(last_oob), 32'h1);
        acc(1'b1, 2'd1, OFS_MONITOR_INDEX, 32'h0100_0003);
        chk(32'(cache_space), 32'h1);
        chk(32'(cache_monitor_index), 32'h3);
        chk(32'(cache_resource_index), 32'h1);
        rd(2'd1, OFS_CSU_VAL, 32'h8000_1234);
        rd(2'd0, 12'h804, 32'h0);
        cfg.realm_extension = 1'b0;
        rd(2'd2, OFS_MONITOR_INDEX, 32'h0);
        rd(2'd3, OFS_BW_FLT, 32'h0);
        cfg.realm_extension = 1'b1;
        rd(2'd2, OFS_MONITOR_INDEX, 32'h0100_0003);
        cfg.monitors_present_flag = 1'b0;
        acc(1'b1, 2'd0, OFS_MONITOR_INDEX, 32'h0000_0005);
        rd(2'd0, OFS_MONITOR_INDEX, 32'h0);
        cfg.monitors_present_flag = 1'b1;
        rd(2'd0, OFS_MONITOR_INDEX, 32'h0000_0008);
        cfg.resource_select_present = 1'b0;
        acc(1'b1, 2'd0, OFS_MONITOR_INDEX, 32'h0100_0001);
        rd(2'd0, OFS_MONITOR_INDEX, 32'h0000_0001);
        rd(2'd0, OFS_BW_FLT, 32'h0);
        tally_and_finish();
    end
endmodule : monitor_instance_select_bank_test
`default_nettype wire
